// *** logic/tpf_pkg.sv ***
// Package with register map, field layout and carrier types of the PID filter.
package tpf_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_BOUNDARY_ID = 8'h00;
  localparam logic [7:0] ADDR_BOUNDARY_STORE = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_REF = 8'h08;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h0C;
  localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h10;
  localparam logic [7:0] ADDR_FILTER_BASE = 8'h20;
  localparam logic [7:0] ADDR_FILTER_LAST = 8'h38;
  localparam int NUM_FILTERS = 7;
  localparam logic [2:0] OTHER_CHANNEL = 3'h7;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int PID_W = 13;
  localparam int SENSE_EN_BIT = 16;
  localparam int FILTER_EN_BIT = 24;
  localparam int KIND_LSB = 16;
  localparam int KIND_MSB = 23;
  localparam int BOUNDARY_CTL_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 2;
  localparam int BOUNDARY_STAT_BIT = 0;
  localparam logic [12:0] BOUNDARY_ID_RESET = 13'h1FFF;
  localparam logic [31:0] STORE_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_SEMI_A = 2'b01,
    MODE_SEMI_B = 2'b10,
    MODE_AUTO = 2'b11
  } tpf_mode_t;

  typedef struct packed {
    logic enable;
    logic [7:0] kind;
    logic [12:0] pid;
  } tpf_filter_t;

  typedef struct packed {
    logic valid;
    logic [12:0] pid;
  } tpf_header_t;

  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [7:0] kind;
    logic boundary;
    logic clockRef;
    logic [31:0] storeAddr;
  } tpf_route_t;

endpackage : tpf_pkg

// *** logic/tpf_filter_bank.sv ***
// Register storage for the seven channel PID filters.
`timescale 1ns/10ps
module tpf_filter_bank (
  input wire logic clock,
  input wire logic nrst,
  input wire logic writeEn,
  input wire logic [2:0] writeIdx,
  input wire logic [31:0] writeData,
  input wire logic [3:0] writeStrb,
  input wire logic [2:0] readIdx,
  output logic [31:0] readData,
  output tpf_pkg::tpf_filter_t filters [tpf_pkg::NUM_FILTERS]
);
  import tpf_pkg::*;

  logic [31:0] readMux;

  // ----------------------------------------------------------------------
  // Storage per filter
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : gFilt
      wire hit = writeEn && (writeIdx == 3'(g));
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          filters[g] <= '0;
        end else if (hit) begin
          if (writeStrb[3]) filters[g].enable <= writeData[FILTER_EN_BIT];
          if (writeStrb[2]) filters[g].kind <= writeData[KIND_MSB:KIND_LSB];
          if (writeStrb[1]) filters[g].pid[12:8] <= writeData[12:8];
          if (writeStrb[0]) filters[g].pid[7:0] <= writeData[7:0];
        end
      end
    end
  endgenerate

  // Reserved bits read as zero.
  assign readMux = (readIdx < 3'(NUM_FILTERS)) ?
    {7'h00, filters[readIdx].enable, filters[readIdx].kind, 3'h0,
     filters[readIdx].pid} : 32'h0000_0000;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) readData <= 32'h0000_0000;
    else readData <= readMux;
  end

endmodule : tpf_filter_bank

// *** logic/tpf_pid_filter.sv ***
// AXI4-Lite register bank and PID routing of the stream filter.
//
// Behaviour
// - Hold a 13-bit boundary packet ID.
// - Boundary ID acts only while boundary control bit is set.
// - A detected boundary packet pulses interrupt and records status.
// - Boundary packet stored from the boundary store start address.
// - Clock-reference sense enable at bit 16 turns clock-ref filtering on.
// - Sense enable honoured only in manual or semi-automatic A mode.
// - Semi-automatic B and automatic modes ignore sense enable.
// - Hold a 13-bit clock-reference packet ID.
// - Packets matching no filter go to ring-buffer channel 7.
// - Bit 24 enables filter n and its ring-buffer channel.
// - Bits 23 to 16 hold the channel stream kind.
// - Bits 12 to 0 hold the channel packet ID.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module tpf_pid_filter (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire tpf_pkg::tpf_header_t header,
  input wire logic [12:0] autoClockRefId,
  output tpf_pkg::tpf_route_t route,
  output logic boundaryPulse,
  output logic [7:0] channelWriteEnable
);
  import tpf_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [12:0] boundaryPacketId;
  logic [31:0] boundaryStoreStartAddress;
  logic [12:0] clockRefPacketId;
  logic clockRefSenseEnable;
  logic streamBoundaryControl;
  tpf_mode_t filterModeSelect;
  logic boundarySeen;
  tpf_filter_t filters [NUM_FILTERS];
  logic [31:0] bankData;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;

  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire [7:0] wrAddr = awTake ? awaddr : awAddrHeld;
  wire [31:0] wrData = wTake ? wdata : wDataHeld;
  wire [3:0] wrStrb = wTake ? wstrb : wStrbHeld;
  wire haveAw = awHeld || awTake;
  wire haveW = wHeld || wTake;
  wire doWrite = haveAw && haveW && !bvalid;
  wire wrFilter = (wrAddr >= ADDR_FILTER_BASE) &&
    (wrAddr <= ADDR_FILTER_LAST) && (wrAddr[1:0] == 2'h0);
  wire [7:0] wrOffset = wrAddr - ADDR_FILTER_BASE;
  wire [2:0] wrIdx = wrOffset[4:2];
  wire wrKnown = wrFilter || (wrAddr == ADDR_BOUNDARY_ID) ||
    (wrAddr == ADDR_BOUNDARY_STORE) || (wrAddr == ADDR_CLOCK_REF) ||
    (wrAddr == ADDR_CONTROL_ONE) || (wrAddr == ADDR_CONTROL_ZERO);
  wire wrHit = doWrite && wrKnown;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awHeld <= haveAw && !doWrite;
      wHeld <= haveW && !doWrite;
      if (awTake) awAddrHeld <= awaddr;
      if (wTake) wDataHeld <= wdata;
      if (wTake) wStrbHeld <= wstrb;
      awready <= !haveAw && !awready && !bvalid;
      wready <= !haveW && !wready && !bvalid;
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Scalar registers
  // ----------------------------------------------------------------------
  wire wrBoundId = wrHit && (wrAddr == ADDR_BOUNDARY_ID);
  wire wrStore = wrHit && (wrAddr == ADDR_BOUNDARY_STORE);
  wire wrClock = wrHit && (wrAddr == ADDR_CLOCK_REF);
  wire wrCtlOne = wrHit && (wrAddr == ADDR_CONTROL_ONE) && wrStrb[0];
  wire clrStatus = wrHit && (wrAddr == ADDR_CONTROL_ZERO) && wrStrb[0] &&
    wrData[BOUNDARY_STAT_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boundaryPacketId <= BOUNDARY_ID_RESET;
    end else if (wrBoundId) begin
      if (wrStrb[1]) boundaryPacketId[12:8] <= wrData[12:8];
      if (wrStrb[0]) boundaryPacketId[7:0] <= wrData[7:0];
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : gStore
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          boundaryStoreStartAddress[b*8 +: 8] <= STORE_RESET[b*8 +: 8];
        end else if (wrStore && wrStrb[b]) begin
          boundaryStoreStartAddress[b*8 +: 8] <= wrData[b*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clockRefPacketId <= 13'h0000;
      clockRefSenseEnable <= 1'b0;
    end else if (wrClock) begin
      if (wrStrb[1]) clockRefPacketId[12:8] <= wrData[12:8];
      if (wrStrb[0]) clockRefPacketId[7:0] <= wrData[7:0];
      if (wrStrb[2]) clockRefSenseEnable <= wrData[SENSE_EN_BIT];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      streamBoundaryControl <= 1'b0;
      filterModeSelect <= MODE_MANUAL;
    end else if (wrCtlOne) begin
      streamBoundaryControl <= wrData[BOUNDARY_CTL_BIT];
      filterModeSelect <= tpf_mode_t'(wrData[MODE_MSB:MODE_LSB]);
    end
  end

  // ----------------------------------------------------------------------
  // Filter bank
  // ----------------------------------------------------------------------
  wire rdFilter = (araddr >= ADDR_FILTER_BASE) &&
    (araddr <= ADDR_FILTER_LAST) && (araddr[1:0] == 2'h0);
  wire [7:0] rdOffset = araddr - ADDR_FILTER_BASE;

  tpf_filter_bank u_tpf_filter_bank (
    .clock(clock),
    .nrst(nrst),
    .writeEn(wrHit && wrFilter),
    .writeIdx(wrIdx),
    .writeData(wrData),
    .writeStrb(wrStrb),
    .readIdx(rdOffset[4:2]),
    .readData(bankData),
    .filters(filters)
  );

  // ----------------------------------------------------------------------
  // Packet routing
  // ----------------------------------------------------------------------
  logic [NUM_FILTERS-1:0] match;
  logic [2:0] matchIdx;
  logic [7:0] matchKind;

  generate
    for (b = 0; b < NUM_FILTERS; b++) begin : gMatch
      assign match[b] = filters[b].enable && (filters[b].pid == header.pid);
    end
  endgenerate

  always_comb begin
    matchIdx = OTHER_CHANNEL;
    matchKind = 8'h00;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (match[i]) begin
        matchIdx = 3'(i);
        matchKind = filters[i].kind;
      end
    end
  end

  wire autoClockMode = (filterModeSelect == MODE_SEMI_B) ||
    (filterModeSelect == MODE_AUTO);
  wire clockSenseOn = autoClockMode ? 1'b1 : clockRefSenseEnable;
  wire [12:0] clockId = autoClockMode ? autoClockRefId : clockRefPacketId;
  wire isClockRef = clockSenseOn && (header.pid == clockId);
  wire isBoundary = streamBoundaryControl &&
    (header.pid == boundaryPacketId);
  wire boundaryHit = header.valid && isBoundary;

  logic [7:0] channelEnables;
  always_comb begin
    channelEnables = 8'h80;
    for (int i = 0; i < NUM_FILTERS; i++) begin
      channelEnables[i] = filters[i].enable;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      route <= '0;
      boundaryPulse <= 1'b0;
      channelWriteEnable <= 8'h00;
    end else begin
      route.valid <= header.valid;
      route.channel <= matchIdx;
      route.kind <= matchKind;
      route.boundary <= boundaryHit;
      route.clockRef <= header.valid && isClockRef;
      route.storeAddr <= boundaryStoreStartAddress;
      boundaryPulse <= boundaryHit;
      channelWriteEnable <= channelEnables;
    end
  end

  // Status is sticky; a new detection wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) boundarySeen <= 1'b0;
    else if (boundaryHit) boundarySeen <= 1'b1;
    else if (clrStatus) boundarySeen <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic rdPending;
  logic rdBank;
  logic [31:0] rdScalar;
  logic rdKnown;

  always_comb begin
    rdKnown = 1'b1;
    unique case (araddr)
      ADDR_BOUNDARY_ID: rdScalar = {19'h00000, boundaryPacketId};
      ADDR_BOUNDARY_STORE: rdScalar = boundaryStoreStartAddress;
      ADDR_CLOCK_REF: rdScalar = {15'h0000, clockRefSenseEnable, 3'h0,
        clockRefPacketId};
      ADDR_CONTROL_ONE: rdScalar = {29'h0, filterModeSelect,
        streamBoundaryControl};
      ADDR_CONTROL_ZERO: rdScalar = {31'h0, boundarySeen};
      default: begin
        rdScalar = 32'h0000_0000;
        rdKnown = rdFilter;
      end
    endcase
  end

  wire arTake = arvalid && arready;
  logic [31:0] rdHold;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b0;
      rdPending <= 1'b0;
      rdBank <= 1'b0;
      rdHold <= 32'h0000_0000;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !arready && !rdPending && !rvalid && arvalid;
      rdPending <= arTake;
      if (arTake) begin
        rdBank <= rdFilter;
        rdHold <= rdScalar;
        rresp <= rdKnown ? RESP_OKAY : RESP_SLVERR;
      end
      if (rdPending) begin
        rvalid <= 1'b1;
        rdata <= rdBank ? bankData : rdHold;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence sBoundaryIn;
    header.valid && streamBoundaryControl &&
      (header.pid == boundaryPacketId);
  endsequence

  a_boundary_pulse: assert property (@(posedge clock)
    disable iff (!nrst) sBoundaryIn |=> boundaryPulse && route.boundary)
    else $error("Boundary packet did not pulse.");
  a_boundary_gated: assert property (@(posedge clock)
    disable iff (!nrst) !streamBoundaryControl |=> !boundaryPulse)
    else $error("Boundary pulse without boundary control.");
  a_boundary_sticky: assert property (@(posedge clock)
    disable iff (!nrst) sBoundaryIn ##1 1'b1 |-> boundarySeen)
    else $error("Boundary status not recorded.");
  a_other_channel: assert property (@(posedge clock)
    disable iff (!nrst) header.valid && (match == '0)
      |=> route.channel == OTHER_CHANNEL)
    else $error("Unmatched packet not sent to channel seven.");
  a_match_steer: assert property (@(posedge clock)
    disable iff (!nrst) header.valid && match[0] |=> route.channel == 3'h0)
    else $error("Match on filter zero not steered.");
  a_sense_manual: assert property (@(posedge clock)
    disable iff (!nrst) header.valid && !autoClockMode && !clockRefSenseEnable
      |=> !route.clockRef)
    else $error("Clock reference sensed while disabled.");
  a_sense_auto: assert property (@(posedge clock)
    disable iff (!nrst) header.valid && autoClockMode &&
      (header.pid == autoClockRefId) |=> route.clockRef)
    else $error("Automatic clock reference missed.");
  a_store_addr: assert property (@(posedge clock)
    disable iff (!nrst)
      sBoundaryIn |=> route.storeAddr == $past(boundaryStoreStartAddress))
    else $error("Boundary store address wrong.");
  a_chan_enable: assert property (@(posedge clock)
    disable iff (!nrst) ##1 channelWriteEnable[0] == $past(filters[0].enable))
    else $error("Channel enable does not follow filter enable.");
  a_reserved_zero: assert property (@(posedge clock)
    disable iff (!nrst) rvalid && rdBank |->
      (rdata[31:25] == 7'h00) && (rdata[15:13] == 3'h0))
    else $error("Reserved filter bits read nonzero.");

endmodule : tpf_pid_filter

// *** bench/test_tpf_pid_filter.sv ***
// Self-checking testbench of the PID filter register bank and routing.
`timescale 1ns/10ps
module test_tpf_pid_filter;
  import tpf_pkg::*;
  logic clock, nrst;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  tpf_header_t header;
  logic [12:0] autoClockRefId;
  tpf_route_t route;
  logic boundaryPulse;
  logic [7:0] channelWriteEnable;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  tpf_pid_filter u_tpf_pid_filter (.clock(clock), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .header(header), .autoClockRefId(autoClockRefId),
    .route(route), .boundaryPulse(boundaryPulse),
    .channelWriteEnable(channelWriteEnable));

  // ----------------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic timed_out;
    $display("MISMATCH handshake expected 1 seen timeout");
    n_fail++;
    give_verdict();
  endtask : timed_out

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic aDone, wDone, aT, wT;
    int n;
    aDone = 0;
    wDone = 0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(negedge clock);
      aT = !aDone && awready === 1'b1;
      wT = !wDone && wready === 1'b1;
      @(posedge clock);
      if (aT) begin
        awvalid <= 1'b0;
        aDone = 1;
      end
      if (wT) begin
        wvalid <= 1'b0;
        wDone = 1;
      end
      if (++n > 50) timed_out();
    end
    n = 0;
    do begin
      @(negedge clock);
      r = bresp;
      if (++n > 50) timed_out();
    end while (bvalid !== 1'b1);
    @(posedge clock);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock);
      if (++n > 50) timed_out();
    end while (arready !== 1'b1);
    @(posedge clock);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      d = rdata;
      r = rresp;
      if (++n > 50) timed_out();
    end while (rvalid !== 1'b1);
    @(posedge clock);
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hF, rs);
    check("write response", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rs);
    check("read response", {30'h0, RESP_OKAY}, {30'h0, rs});
    check("read data", e, rd);
  endtask : rd_check

  task automatic send_header(input logic [12:0] p);
    @(posedge clock);
    header <= {1'b1, p};
    @(posedge clock);
    header <= {1'b0, 13'h0000};
    #1;
    check("route valid", 32'h1, {31'h0, route.valid});
  endtask : send_header

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset_values;
    rd_check(ADDR_BOUNDARY_ID, 32'h0000_1FFF);
    rd_check(ADDR_BOUNDARY_STORE, 32'h0000_0000);
    rd_check(ADDR_CLOCK_REF, 32'h0000_0000);
    rd_check(ADDR_CONTROL_ONE, 32'h0000_0000);
    rd_check(ADDR_CONTROL_ZERO, 32'h0000_0000);
    for (int i = 0; i < NUM_FILTERS; i++) begin
      rd_check(ADDR_FILTER_BASE + 8'(4 * i), 32'h0000_0000);
    end
    check("write enables", 32'h80, {24'h0, channelWriteEnable});
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_reserved_bits;
    wr(ADDR_BOUNDARY_ID, 32'hFFFF_FFFF);
    rd_check(ADDR_BOUNDARY_ID, 32'h0000_1FFF);
    wr(ADDR_BOUNDARY_STORE, 32'hFFFF_FFFF);
    rd_check(ADDR_BOUNDARY_STORE, 32'hFFFF_FFFF);
    wr(ADDR_CLOCK_REF, 32'hFFFF_FFFF);
    rd_check(ADDR_CLOCK_REF, 32'h0001_1FFF);
    wr(ADDR_FILTER_BASE + 8'h0C, 32'hFFFF_FFFF);
    rd_check(ADDR_FILTER_BASE + 8'h0C, 32'h01FF_1FFF);
    axi_write(ADDR_FILTER_BASE + 8'h0C, 32'h0000_0000, 4'h1, rs);
    rd_check(ADDR_FILTER_BASE + 8'h0C, 32'h01FF_1F00);
    axi_write(8'h14, 32'hFFFF_FFFF, 4'hF, rs);
    check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    axi_read(8'h14, rd, rs);
    check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
    check("unmapped data", 32'h0, rd);
    wr(ADDR_FILTER_BASE + 8'h0C, 32'h0000_0000);
    $display("test reserved bits done");
  endtask : test_reserved_bits

  task automatic test_routing;
    for (int i = 0; i < NUM_FILTERS; i++) begin
      wr(ADDR_FILTER_BASE + 8'(4 * i), {7'h0, i != 4, 8'(8'h10 + i),
         3'h0, i == 6 ? 13'h0101 : 13'(13'h0100 + i)});
    end
    @(posedge clock);
    #1;
    check("write enables", 32'hEF, {24'h0, channelWriteEnable});
    for (int i = 0; i < 6; i++) begin
      send_header(13'(13'h0100 + i));
      check("channel", i == 4 ? 32'h7 : 32'(i), {29'h0, route.channel});
      if (i != 4) check("kind", 32'(8'h10 + i), {24'h0, route.kind});
    end
    send_header(13'h1ABC);
    check("other channel", 32'h7, {29'h0, route.channel});
    $display("test routing done");
  endtask : test_routing

  task automatic test_boundary;
    wr(ADDR_BOUNDARY_ID, 32'h0000_0ABC);
    wr(ADDR_BOUNDARY_STORE, 32'h89AB_CDEF);
    wr(ADDR_CONTROL_ONE, 32'h0000_0000);
    send_header(13'h0ABC);
    check("pulse off", 32'h0, {31'h0, boundaryPulse});
    check("boundary off", 32'h0, {31'h0, route.boundary});
    axi_read(ADDR_CONTROL_ZERO, rd, rs);
    check("status clear", 32'h0, {31'h0, rd[0]});
    wr(ADDR_CONTROL_ONE, 32'h0000_0001);
    send_header(13'h0ABC);
    check("pulse on", 32'h1, {31'h0, boundaryPulse});
    check("boundary on", 32'h1, {31'h0, route.boundary});
    check("store address", 32'h89AB_CDEF, route.storeAddr);
    @(posedge clock);
    #1;
    check("pulse width", 32'h0, {31'h0, boundaryPulse});
    axi_read(ADDR_CONTROL_ZERO, rd, rs);
    check("status set", 32'h1, {31'h0, rd[0]});
    wr(ADDR_CONTROL_ZERO, 32'h0000_0001);
    axi_read(ADDR_CONTROL_ZERO, rd, rs);
    check("status cleared", 32'h0, {31'h0, rd[0]});
    $display("test boundary done");
  endtask : test_boundary

  task automatic test_clock_ref;
    for (int e = 1; e >= 0; e--) begin
      wr(ADDR_CLOCK_REF, {15'h0, e == 1, 3'h0, 13'h0DEF});
      for (int m = 0; m < 4; m++) begin
        wr(ADDR_CONTROL_ONE, 32'(m << 1));
        rd_check(ADDR_CONTROL_ONE, 32'(m << 1));
        send_header(13'h0DEF);
        check("manual ref", 32'(m < 2 && e == 1),
              {31'h0, route.clockRef});
        send_header(13'h0123);
        check("auto ref", 32'(m >= 2), {31'h0, route.clockRef});
      end
    end
    $display("test clock ref done");
  endtask : test_clock_ref

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end

  initial begin
    nrst = 0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    header = '0;
    autoClockRefId = 13'h0123;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    test_reset_values();
    test_reserved_bits();
    test_routing();
    test_boundary();
    test_clock_ref();
    give_verdict();
  end
endmodule : test_tpf_pid_filter
